// ===== shared/loader_pkg.sv
// Shared constants and carrier types for the configuration word loader.
package loader_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_PORTS = 4;
  localparam int NUM_FUNCS = 3;

  // ---------------------------------------------------------------------------
  // Serial memory word addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] W_FUNC2_REV  = 8'h4C;
  localparam logic [7:0] W_USB_PHY1   = 8'h4E;
  localparam logic [7:0] W_PORT0_SR   = 8'h50;
  localparam logic [7:0] W_PORT0_DATA = 8'h51;
  localparam logic [7:0] W_PORT_STEP  = 8'h02;
  localparam logic [7:0] W_CLASS_F0   = 8'h58;
  localparam logic [7:0] W_CLASS_STEP = 8'h02;
  localparam logic [7:0] W_USB_PHY2   = 8'h5E;

  // ---------------------------------------------------------------------------
  // Field positions inside a soft-reset word and in the target registers
  // ---------------------------------------------------------------------------
  localparam int SR_NSR_BIT    = 0;
  localparam int SR_AUX_LSB    = 1;
  localparam int SR_PME_LSB    = 6;
  localparam int CAP_AUX_LSB   = 22;
  localparam int CAP_D1_BIT    = 25;
  localparam int CAP_D2_BIT    = 26;
  localparam int CAP_PME_LSB   = 28;
  localparam int PMC_NSR_BIT   = 3;
  localparam int PMC_DATA_LSB  = 24;

  // ---------------------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------------------
  localparam logic [31:0] PM_CAP_RESET  = 32'h0600_0000;
  localparam logic [31:0] PM_CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [15:0] USB_PHY_RESET = 16'h0000;
  localparam logic        LOAD_EN_RESET = 1'b1;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [7:0] REG_FUNC2_REV  = 8'h08;
  localparam logic [7:0] REG_USB_PHY1   = 8'h0C;
  localparam logic [7:0] REG_USB_PHY2   = 8'h10;
  localparam logic [7:0] REG_PM_BASE    = 8'h14;
  localparam logic [7:0] REG_PM_STEP    = 8'h08;
  localparam logic [7:0] REG_PM_CTRL    = 8'h04;
  localparam logic [7:0] REG_CLASS_BASE = 8'h34;
  localparam logic [7:0] REG_CLASS_STEP = 8'h04;
  localparam int         CTRL_LOAD_EN   = 0;
  localparam int         STAT_PRESENT   = 8;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } loader_word_s;

  typedef struct packed {
    logic [7:0]            f2_revision;
    logic [7:0]            f2_prog_if;
    logic [15:0]           usb_phy1;
    logic [15:0]           usb_phy2;
    logic [2:0][7:0]       sub_class;
    logic [2:0][7:0]       base_class;
  } cfg_fields_s;

endpackage : loader_pkg

// ===== src/pm_port_fields.sv
// Power-management capability and control fields of one bridge port.
`timescale 1ns/1ps
module pm_port_fields (
  input  wire logic        clk,          // Core clock
  input  wire logic        rst_n,        // Synchronised reset, active low
  input  wire logic        load_sr,      // Apply soft-reset word this cycle
  input  wire logic        load_data,    // Apply data word this cycle
  input  wire logic [15:0] word_data,    // Word from configuration memory
  output logic      [31:0] pm_cap,       // Capability register image
  output logic      [31:0] pm_ctrl       // Control/data register image
);

  // ---------------------------------------------------------------------------
  // Capability register
  // ---------------------------------------------------------------------------
  // D1 and D2 support stay at one whatever the word says, so word bits 4 and 5
  // are deliberately dropped.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pm_cap <= loader_pkg::PM_CAP_RESET;
    end else if (load_sr) begin
      pm_cap[loader_pkg::CAP_AUX_LSB +: 3] <= word_data[loader_pkg::SR_AUX_LSB +: 3];
      pm_cap[loader_pkg::CAP_D1_BIT]       <= 1'b1;
      pm_cap[loader_pkg::CAP_D2_BIT]       <= 1'b1;
      pm_cap[loader_pkg::CAP_PME_LSB +: 2] <= word_data[loader_pkg::SR_PME_LSB +: 2];
    end
  end

  // ---------------------------------------------------------------------------
  // Control and data register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pm_ctrl <= loader_pkg::PM_CTRL_RESET;
    end else begin
      if (load_sr) begin
        pm_ctrl[loader_pkg::PMC_NSR_BIT] <= word_data[loader_pkg::SR_NSR_BIT];
      end
      if (load_data) begin
        pm_ctrl[loader_pkg::PMC_DATA_LSB +: 8] <= word_data[15:8];
      end
    end
  end

endmodule : pm_port_fields

// ===== src/eeprom_config_word_loader.sv
// Configuration word loader: serial-memory words into configuration fields.
//
// Behaviour
// - Word 4Ch low byte to function 2 revision, high byte to programming interface.
// - Word 4Eh fully copied to USB port 1 physical-layer control, all functions.
// - Word 50h bit 0 sets port 0 no-soft-reset flag, control bit 3.
// - Soft-reset word bits 3:1 load auxiliary current, capability bits 24:22.
// - Capability bit 25, D1 support, reads as one and is read-only.
// - Capability bit 26, D2 support, reads as one and is read-only.
// - Soft-reset word bits 7:6 load wake-event support, capability bits 29:28.
// - Word 51h high byte loads port 0 data byte, bits 31:24, read-only.
// - Ports 1 to 3 use word pairs 52h/53h, 54h/55h, 56h/57h alike.
// - Words 58h, 5Ah, 5Ch set sub-class low byte and base class high.
// - Word 5Eh fully copied to USB port 2 physical-layer control, all functions.
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module eeprom_config_word_loader (
  input  wire logic                     sys_clk,          // Core clock, 25 MHz
  input  wire logic                     reset_n,          // Asynchronous reset, active low
  input  wire logic                     mem_present,      // Valid configuration memory detected
  input  wire logic                     word_valid,       // Word strobe from memory reader
  input  wire loader_pkg::loader_word_s word_in,          // Word address and data
  output loader_pkg::cfg_fields_s       fields,           // Function fields
  output logic [3:0][31:0]              pm_cap,           // Per-port capability images
  output logic [3:0][31:0]              pm_ctrl,          // Per-port control images
  input  wire logic [7:0]               avs_address,      // Byte address
  input  wire logic                     avs_read,         // Read request
  input  wire logic                     avs_write,        // Write request
  input  wire logic [31:0]              avs_writedata,    // Write data
  input  wire logic [3:0]               avs_byteenable,   // Byte lanes
  output logic [31:0]                   avs_readdata,     // Read data
  output logic                          avs_waitrequest   // Stall
);

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Word acceptance
  // ---------------------------------------------------------------------------
  logic        load_en_r;
  logic        apply;
  logic [7:0]  words_loaded_r;
  logic [7:0]  waddr;
  logic [15:0] wdata;

  assign waddr = word_in.addr;
  assign wdata = word_in.data;
  // A missing memory would feed garbage, so nothing lands without it.
  assign apply = word_valid && mem_present && load_en_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      words_loaded_r <= 8'h00;
    end else if (apply && words_loaded_r != 8'hFF) begin
      words_loaded_r <= words_loaded_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Function 2 revision and USB physical-layer control
  // ---------------------------------------------------------------------------
  logic [7:0]  f2_rev_r;
  logic [7:0]  f2_progif_r;
  logic [15:0] usb_phy1_r;
  logic [15:0] usb_phy2_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      f2_rev_r    <= loader_pkg::BYTE_RESET;
      f2_progif_r <= loader_pkg::BYTE_RESET;
    end else if (apply && waddr == loader_pkg::W_FUNC2_REV) begin
      f2_rev_r    <= wdata[7:0];
      f2_progif_r <= wdata[15:8];
    end
  end

  // One copy serves functions 0 to 2, which all see the same value.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      usb_phy1_r <= loader_pkg::USB_PHY_RESET;
      usb_phy2_r <= loader_pkg::USB_PHY_RESET;
    end else if (apply) begin
      if (waddr == loader_pkg::W_USB_PHY1) begin
        usb_phy1_r <= wdata;
      end
      if (waddr == loader_pkg::W_USB_PHY2) begin
        usb_phy2_r <= wdata;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Class codes and bridge ports
  // ---------------------------------------------------------------------------
  logic [2:0][7:0] sub_class_r;
  logic [2:0][7:0] base_class_r;

  for (genvar f = 0; f < loader_pkg::NUM_FUNCS; f++) begin : g_class
    localparam logic [7:0] CLASS_ADDR = 8'(loader_pkg::W_CLASS_F0 + 8'(f) * loader_pkg::W_CLASS_STEP);
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        sub_class_r[f]  <= loader_pkg::BYTE_RESET;
        base_class_r[f] <= loader_pkg::BYTE_RESET;
      end else if (apply && waddr == CLASS_ADDR) begin
        sub_class_r[f]  <= wdata[7:0];
        base_class_r[f] <= wdata[15:8];
      end
    end
  end

  for (genvar p = 0; p < loader_pkg::NUM_PORTS; p++) begin : g_port
    localparam logic [7:0] SR_ADDR   = 8'(loader_pkg::W_PORT0_SR + 8'(p) * loader_pkg::W_PORT_STEP);
    localparam logic [7:0] DATA_ADDR = 8'(loader_pkg::W_PORT0_DATA + 8'(p) * loader_pkg::W_PORT_STEP);
    pm_port_fields u_pm (
      .clk       (sys_clk),
      .rst_n     (rst_n),
      .load_sr   (apply && waddr == SR_ADDR),
      .load_data (apply && waddr == DATA_ADDR),
      .word_data (wdata),
      .pm_cap    (pm_cap[p]),
      .pm_ctrl   (pm_ctrl[p])
    );
  end

  assign fields.f2_revision = f2_rev_r;
  assign fields.f2_prog_if  = f2_progif_r;
  assign fields.usb_phy1    = usb_phy1_r;
  assign fields.usb_phy2    = usb_phy2_r;
  assign fields.sub_class   = sub_class_r;
  assign fields.base_class  = base_class_r;

  // ---------------------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------------------
  // Every access stalls exactly one cycle so read data come from a flop.
  logic        ack_r;
  logic        req;
  logic [31:0] rd_mux;

  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  // Loaded fields are read-only to software; only the enable is writable.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      loader_pkg::REG_CTRL:      rd_mux[loader_pkg::CTRL_LOAD_EN] = load_en_r;
      loader_pkg::REG_STATUS:    rd_mux = {23'h000000, mem_present, words_loaded_r};
      loader_pkg::REG_FUNC2_REV: rd_mux = {16'h0000, f2_progif_r, f2_rev_r};
      loader_pkg::REG_USB_PHY1:  rd_mux = {16'h0000, usb_phy1_r};
      loader_pkg::REG_USB_PHY2:  rd_mux = {16'h0000, usb_phy2_r};
      default: begin
        for (int i = 0; i < loader_pkg::NUM_PORTS; i++) begin
          if (avs_address == 8'(loader_pkg::REG_PM_BASE + 8'(i) * loader_pkg::REG_PM_STEP)) begin
            rd_mux = pm_cap[i];
          end
          if (avs_address == 8'(loader_pkg::REG_PM_BASE + 8'(i) * loader_pkg::REG_PM_STEP
                                + loader_pkg::REG_PM_CTRL)) begin
            rd_mux = pm_ctrl[i];
          end
        end
        for (int i = 0; i < loader_pkg::NUM_FUNCS; i++) begin
          if (avs_address == 8'(loader_pkg::REG_CLASS_BASE + 8'(i) * loader_pkg::REG_CLASS_STEP)) begin
            rd_mux = {16'h0000, base_class_r[i], sub_class_r[i]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_en_r <= loader_pkg::LOAD_EN_RESET;
    end else if (avs_write && ack_r && avs_address == loader_pkg::REG_CTRL && avs_byteenable[0]) begin
      load_en_r <= avs_writedata[loader_pkg::CTRL_LOAD_EN];
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  f2_rev_load_a: assert property (apply && waddr == loader_pkg::W_FUNC2_REV |=>
      fields.f2_revision == $past(wdata[7:0]) && fields.f2_prog_if == $past(wdata[15:8]))
    else $error("Function 2 revision or interface byte not loaded");

  usb_phy1_load_a: assert property (apply && waddr == loader_pkg::W_USB_PHY1 |=>
      fields.usb_phy1 == $past(wdata))
    else $error("USB port 1 control not loaded");

  usb_phy2_load_a: assert property (apply && waddr == loader_pkg::W_USB_PHY2 |=>
      fields.usb_phy2 == $past(wdata))
    else $error("USB port 2 control not loaded");

  port0_nsr_a: assert property (apply && waddr == loader_pkg::W_PORT0_SR |=>
      pm_ctrl[0][3] == $past(wdata[0]))
    else $error("Port 0 no-soft-reset flag wrong");

  port0_aux_a: assert property (apply && waddr == loader_pkg::W_PORT0_SR |=>
      pm_cap[0][24:22] == $past(wdata[3:1]))
    else $error("Port 0 auxiliary current wrong");

  d1_d2_one_a: assert property (pm_cap[0][26:25] == 2'b11 && pm_cap[1][26:25] == 2'b11
      && pm_cap[2][26:25] == 2'b11 && pm_cap[3][26:25] == 2'b11)
    else $error("D1 or D2 support bit not one");

  port0_pme_a: assert property (apply && waddr == loader_pkg::W_PORT0_SR |=>
      pm_cap[0][29:28] == $past(wdata[7:6]) ##1 pm_cap[0][29:28] == $past(pm_cap[0][29:28]) || $past(apply))
    else $error("Port 0 wake support wrong");

  port0_data_a: assert property (apply && waddr == loader_pkg::W_PORT0_DATA |=>
      pm_ctrl[0][31:24] == $past(wdata[15:8]) && $stable(pm_ctrl[0][3]))
    else $error("Port 0 data byte wrong");

  port3_pair_a: assert property (apply && waddr == 8'h56 |=>
      pm_ctrl[3][3] == $past(wdata[0]) && $stable(pm_ctrl[2]))
    else $error("Port 3 soft-reset word misrouted");

  class_f1_a: assert property (apply && waddr == 8'h5A |=>
      fields.sub_class[1] == $past(wdata[7:0]) && fields.base_class[1] == $past(wdata[15:8])
      && $stable(fields.sub_class[0]))
    else $error("Function 1 class code wrong");

  no_mem_hold_a: assert property (!mem_present |=> $stable(fields) && $stable(pm_cap)
      && $stable(pm_ctrl))
    else $error("Field changed without valid memory");

  bus_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus answer later than one stall cycle");

  // The enable gate is the only way software can stop a load, so a disabled
  // loader must leave every field exactly as it was.
  load_gate_a: assert property (word_valid && !load_en_r |=> $stable(fields) && $stable(pm_cap)
      && $stable(pm_ctrl))
    else $error("Field changed while loading was disabled");

  class_f2_a: assert property (apply && waddr == 8'h5C |=>
      fields.sub_class[2] == $past(wdata[7:0]) && fields.base_class[2] == $past(wdata[15:8])
      && $stable(fields.sub_class[1]))
    else $error("Function 2 class code wrong");

  port1_cap_a: assert property (apply && waddr == 8'h52 |=>
      pm_cap[1][24:22] == $past(wdata[3:1]) && pm_cap[1][29:28] == $past(wdata[7:6]) && $stable(pm_cap[0]))
    else $error("Port 1 capability word misrouted");

  port2_data_a: assert property (apply && waddr == 8'h55 |=>
      pm_ctrl[2][31:24] == $past(wdata[15:8]) && $stable(pm_cap[2]))
    else $error("Port 2 data word misrouted");

  // Loaded fields are read-only; a bus write may only ever touch the enable.
  ro_write_a: assert property (avs_write && !avs_waitrequest && !apply |=>
      $stable(pm_cap) && $stable(pm_ctrl) && $stable(fields))
    else $error("Bus write changed a loaded field");

  read_data_a: assert property (avs_read && !avs_waitrequest |->
      avs_readdata == $past(rd_mux))
    else $error("Read data not captured in the stall cycle");

  load_en_write_a: assert property (avs_write && !avs_waitrequest && avs_address == loader_pkg::REG_CTRL
      && avs_byteenable[0] |=> load_en_r == $past(avs_writedata[loader_pkg::CTRL_LOAD_EN]))
    else $error("Load enable not written");

  apply_port_c:  cover property (apply && waddr == loader_pkg::W_PORT0_SR ##1 apply
                                 && waddr == loader_pkg::W_PORT0_DATA);
  apply_class_c: cover property (apply && waddr == loader_pkg::W_CLASS_F0);
  bus_read_c:    cover property (avs_read && !avs_waitrequest);
  disable_c:     cover property (word_valid && mem_present && !load_en_r);
  ro_write_c:    cover property (avs_write && !avs_waitrequest && avs_address != loader_pkg::REG_CTRL);

endmodule : eeprom_config_word_loader

// ===== test/cfg_mem_model.sv
// Behavioural serial configuration memory that streams loader words on request.
`timescale 1ns/1ps
module cfg_mem_model (
  input  wire logic                clk,        // Core clock
  input  wire logic                fetch,      // Request one word
  input  wire logic [7:0]          fetch_addr, // Word address to send
  input  wire logic [3:0]          gap,        // Idle cycles before the word
  output logic                     busy,       // Transfer in progress
  output logic                     word_valid, // Word strobe, one cycle
  output loader_pkg::loader_word_s word_in     // Word address and data
);
  logic [15:0] mem [0:255];
  logic [3:0]  wait_r;
  logic [7:0]  addr_r;

  initial begin
    busy       = 1'b0;
    word_valid = 1'b0;
    word_in    = '0;
    wait_r     = 4'h0;
    addr_r     = 8'h00;
  end

  // Between strobes the word lines toggle, so a loader that samples them unqualified picks up junk.
  always @(posedge clk) begin
    word_valid <= 1'b0;
    word_in    <= ~word_in;
    if (!busy && fetch) begin
      busy   <= 1'b1;
      wait_r <= gap;
      addr_r <= fetch_addr;
    end else if (busy && wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end else if (busy) begin
      busy       <= 1'b0;
      word_valid <= 1'b1;
      word_in    <= {addr_r, mem[addr_r]};
    end
  end
endmodule : cfg_mem_model

// ===== test/eeprom_config_word_loader_test.sv
// Self-checking bench for the configuration word loader.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module eeprom_config_word_loader_test;
  logic                      sys_clk, reset_n, mem_present, word_valid, busy, fetch;
  logic [7:0]                fetch_addr, avs_address;
  logic [3:0]                gap, avs_byteenable;
  loader_pkg::loader_word_s  word_in;
  loader_pkg::cfg_fields_s   fields;
  logic [3:0][31:0]          pm_cap, pm_ctrl;
  logic                      avs_read, avs_write, avs_waitrequest;
  logic [31:0]               avs_writedata, avs_readdata, cap_x, ctl_x;
  logic [15:0]               sr, dt, d;
  logic [63:0]               exp_q[$];
  logic [63:0]               mon_note;
  int                        fail_count, n_compared;

  eeprom_config_word_loader DUT (.sys_clk(sys_clk), .reset_n(reset_n), .mem_present(mem_present),
    .word_valid(word_valid), .word_in(word_in), .fields(fields), .pm_cap(pm_cap), .pm_ctrl(pm_ctrl),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  cfg_mem_model u_mem (.clk(sys_clk), .fetch(fetch), .fetch_addr(fetch_addr), .gap(gap), .busy(busy),
    .word_valid(word_valid), .word_in(word_in));

  // ---------------------------------------------------------------------------
  // Drivers and monitor
  // ---------------------------------------------------------------------------
  task automatic stop_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // One Avalon access; a read leaves its expected value and mask as a note for the monitor.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [63:0] note);
    int n;
    n = 0;
    if (!wr) exp_q.push_back(note);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 50) begin
      fail_count++;
      stop_test();
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic send(input logic [7:0] a, input logic [15:0] wd, input logic [3:0] g);
    int n;
    n = 0;
    u_mem.mem[a] = wd;
    fetch      <= 1'b1;
    fetch_addr <= a;
    gap        <= g;
    @(posedge sys_clk);
    fetch <= 1'b0;
    @(negedge sys_clk);
    while (busy === 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 50) begin
      fail_count++;
      stop_test();
    end
    @(posedge sys_clk);
  endtask : send

  always @(posedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) `CHK("read note", 1'b1, 1'b0)
      else begin
        mon_note = exp_q.pop_front();
        `CHK("readdata", mon_note[31:0], avs_readdata & mon_note[63:32])
      end
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {reset_n, avs_read, avs_write, fetch, fail_count, n_compared} = '0;
    {fetch_addr, gap, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    mem_present    = 1'b1;
    void'($urandom(32'hFC25FE36));
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, loader_pkg::REG_CTRL, 32'h0, {32'hFFFF_FFFF, 32'h0000_0001});
    bus(1'b0, loader_pkg::REG_STATUS, 32'h0, {32'h0000_0100, 32'h0000_0100});
    d = 16'($urandom);
    send(loader_pkg::W_FUNC2_REV, d, 4'h0);
    bus(1'b0, loader_pkg::REG_FUNC2_REV, 32'h0, {32'hFFFF_FFFF, 16'h0000, d});
    d = 16'($urandom);
    send(loader_pkg::W_USB_PHY1, d, 4'h5);
    bus(1'b0, loader_pkg::REG_USB_PHY1, 32'h0, {32'hFFFF_FFFF, 16'h0000, d});
    d = 16'($urandom);
    send(loader_pkg::W_USB_PHY2, d, 4'h2);
    bus(1'b0, loader_pkg::REG_USB_PHY2, 32'h0, {32'hFFFF_FFFF, 16'h0000, d});
    for (int p = 0; p < 4; p++) begin
      bus(1'b0, 8'(loader_pkg::REG_PM_BASE + 8'(p * 8)), 32'h0, {32'hFFFF_FFFF, loader_pkg::PM_CAP_RESET});
      sr = 16'($urandom);
      dt = 16'($urandom);
      if (p == 0) sr[5:4] = 2'b00;
      cap_x        = loader_pkg::PM_CAP_RESET;
      cap_x[24:22] = sr[3:1];
      cap_x[29:28] = sr[7:6];
      ctl_x        = 32'h0;
      ctl_x[3]     = sr[0];
      ctl_x[31:24] = dt[15:8];
      send(8'(loader_pkg::W_PORT0_SR + 8'(p * 2)), sr, 4'(p));
      send(8'(loader_pkg::W_PORT0_DATA + 8'(p * 2)), dt, 4'h0);
      bus(1'b0, 8'(loader_pkg::REG_PM_BASE + 8'(p * 8)), 32'h0, {32'hFFFF_FFFF, cap_x});
      bus(1'b0, 8'(loader_pkg::REG_PM_BASE + 8'(p * 8 + 4)), 32'h0, {32'hFFFF_FFFF, ctl_x});
    end
    bus(1'b1, loader_pkg::REG_PM_BASE + 8'h18, 32'hFFFF_FFFF, 64'h0);
    bus(1'b1, loader_pkg::REG_PM_BASE + 8'h1C, 32'h0000_0000, 64'h0);
    bus(1'b0, loader_pkg::REG_PM_BASE + 8'h18, 32'h0, {32'hFFFF_FFFF, cap_x});
    bus(1'b0, loader_pkg::REG_PM_BASE + 8'h1C, 32'h0, {32'hFFFF_FFFF, ctl_x});
    for (int f = 0; f < 3; f++) begin
      d = 16'($urandom);
      send(8'(loader_pkg::W_CLASS_F0 + 8'(f * 2)), d, 4'h1);
      bus(1'b0, 8'(loader_pkg::REG_CLASS_BASE + 8'(f * 4)), 32'h0, {32'hFFFF_FFFF, 16'h0000, d});
    end
    d = 16'($urandom);
    send(loader_pkg::W_USB_PHY1, d, 4'h0);
    mem_present <= 1'b0;
    @(posedge sys_clk);
    send(loader_pkg::W_USB_PHY1, ~d, 4'h0);
    bus(1'b0, loader_pkg::REG_USB_PHY1, 32'h0, {32'hFFFF_FFFF, 16'h0000, d});
    bus(1'b0, loader_pkg::REG_STATUS, 32'h0, {32'h0000_0100, 32'h0000_0000});
    mem_present <= 1'b1;
    bus(1'b1, loader_pkg::REG_CTRL, 32'h0000_0000, 64'h0);
    send(loader_pkg::W_USB_PHY1, ~d, 4'h0);
    bus(1'b0, loader_pkg::REG_USB_PHY1, 32'h0, {32'hFFFF_FFFF, 16'h0000, d});
    bus(1'b1, loader_pkg::REG_CTRL, 32'h0000_0001, 64'h0);
    send(loader_pkg::W_USB_PHY1, ~d, 4'h3);
    bus(1'b0, loader_pkg::REG_USB_PHY1, 32'h0, {32'hFFFF_FFFF, 16'h0000, ~d});
    bus(1'b0, 8'hFC, 32'h0, {32'hFFFF_FFFF, 32'h0000_0000});
    stop_test();
  end
endmodule : eeprom_config_word_loader_test
